// ---- logic/disk_serial_command_status_responder.sv ----
`timescale 1ns/1ns
`default_nettype none
module disk_serial_command_status_responder #(
    parameter int HS_LIMIT_CYCLES = disk_cmd_pkg::HS_CYCLES,
    parameter int TRACK_OFS_CYCLES = disk_cmd_pkg::TRACK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic seek_fault,
    input wire logic write_fault,
    input wire logic write_gate,
    input wire logic vu_status_avail,
    input wire logic reinit_fault,
    output logic attention,
    output logic cmd_complete,
    output logic spindle_run,
    output logic write_enable,
    output logic strobe_offset,
    output logic track_offset
);
    import disk_cmd_pkg::*;

    state_type q, d;

    logic apb_setup;
    logic apb_done;
    logic unmapped;
    logic exec;
    logic busy;
    logic parity_ok;
    logic [3:0] fn;
    logic [3:0] mdf;
    logic [11:0] param;
    logic [15:0] stat_word;
    logic [15:0] cfg_word;
    logic [7:0] spt_now;
    logic [7:0] spt_switch;
    logic [7:0] heads;
    logic [15:0] bps_now;
    logic [15:0] spt_from_param;
    logic [8:1] set_bits;
    logic clr_all;
    logic error_state;

    assign apb_setup = psel && !penable && !q.pready;
    assign apb_done = psel && penable && q.pready;
    assign unmapped = !(paddr == ADDR_CMD || paddr == ADDR_RESP
                      || paddr == ADDR_STAT || paddr == ADDR_SWITCH);
    assign exec = apb_done && pwrite && paddr == ADDR_CMD;
    assign busy = q.phase != PH_IDLE;
    assign parity_ok = ^pwdata[CMD_PARITY_BIT:0];
    assign fn = pwdata[CMD_FN_LSB +: 4];
    assign mdf = pwdata[CMD_MOD_LSB +: 4];
    assign param = pwdata[11:0];
    assign error_state = (|q.flags[7:1]) || seek_fault || write_fault;

    // The divisor is forced non-zero so a rejected zero parameter never yields X.
    assign spt_from_param = BYTES_PER_TRACK / ((param == 12'h000) ? 16'd1 : {4'h0, param});
    assign bps_now = BYTES_PER_TRACK / {8'h00, spt_now};

    always_comb begin
        case (q.switches[SW_SPT_LSB +: 2])
            2'd0: spt_switch = 8'd17;
            2'd1: spt_switch = 8'd16;
            2'd2: spt_switch = 8'd34;
            default: spt_switch = 8'd32;
        endcase
        case (q.switches[SW_HEADS_LSB +: 2])
            2'd1: heads = 8'd7;
            2'd2: heads = 8'd5;
            default: heads = 8'd9;
        endcase
        spt_now = q.spt_set ? q.spt_user : spt_switch;
    end

    always_comb begin
        stat_word = STAT_FIXED;
        stat_word[ST_SPINDLE] = !q.spindle;
        stat_word[8:1] = q.flags;
    end

    always_comb begin
        cfg_word = 16'h0000;
        case (mdf)
            MOD_CFG_GENERAL: begin
                cfg_word = CFG_GENERAL_FIXED;
                cfg_word[CFG_MOTOR_BIT] = q.switches[SW_MOTOR];
                case (q.switches[SW_FMT_LSB +: 2])
                    2'd0: cfg_word[2] = 1'b1;
                    2'd1: cfg_word[0] = 1'b1;
                    default: cfg_word[1] = 1'b1;
                endcase
            end
            MOD_CFG_CYL_FIXED: cfg_word = MAX_CYLINDERS;
            MOD_CFG_CYL_REMOV: cfg_word = 16'h0000;
            MOD_CFG_HEADS: cfg_word = {8'h00, heads};
            MOD_CFG_BPT: cfg_word = BYTES_PER_TRACK;
            MOD_CFG_BPS: cfg_word = bps_now;
            MOD_CFG_SPT: cfg_word = {8'h00, spt_now};
            MOD_CFG_ISG: cfg_word = ISG_WORD;
            MOD_CFG_PLO: cfg_word = PLO_WORD;
            MOD_CFG_VU_WORDS: cfg_word = VU_WORDS;
            default: cfg_word = 16'h0000;
        endcase
    end

    always_comb begin
        d = q;
        set_bits = 8'h00;
        clr_all = 1'b0;

        // APB slave: the answer is prepared in the setup cycle so that pready,
        // prdata and pslverr can all come straight from flip-flops.
        if (apb_setup) begin
            d.pready = 1'b1;
            d.pslverr = unmapped;
            d.prdata = 32'h0000_0000;
            case (paddr)
                ADDR_RESP: d.prdata = {15'h0000, busy && q.phase == PH_RESP_WAIT, q.resp};
                ADDR_STAT: d.prdata = {10'h000, q.strobe_ofs, q.track_ofs, q.write_en,
                                       q.spindle, q.complete, q.attention, stat_word};
                ADDR_SWITCH: d.prdata = {24'h000000, q.switches};
                default: d.prdata = 32'h0000_0000;
            endcase
        end
        if (apb_done) begin
            d.pready = 1'b0;
            d.pslverr = 1'b0;
            if (pwrite && paddr == ADDR_SWITCH) begin
                d.switches = pwdata[7:0];
            end
        end

        // Pending word or offset settling; the host must not speak meanwhile.
        case (q.phase)
            PH_TRACK_WAIT: begin
                d.timer = q.timer + 24'h000001;
                if (q.timer == 24'(TRACK_OFS_CYCLES - 1)) begin
                    d.phase = PH_IDLE;
                end
            end
            PH_RESP_WAIT: begin
                d.timer = q.timer + 24'h000001;
                if (apb_done && !pwrite && paddr == ADDR_RESP) begin
                    d.phase = PH_IDLE;
                end else if (q.timer == 24'(HS_LIMIT_CYCLES - 1)) begin
                    set_bits[ST_IFACE] = 1'b1;
                    d.phase = PH_IDLE;
                end
            end
            default: d.phase = PH_IDLE;
        endcase

        if (exec) begin
            if (busy) begin
                set_bits[ST_IFACE] = 1'b1;
            end else if (!parity_ok) begin
                set_bits[ST_PARITY] = 1'b1;
            end else begin
                case (fn)
                    FN_SEEK, FN_RECAL: begin
                    end
                    FN_STATUS: begin
                        d.resp = (mdf == 4'h0) ? stat_word : 16'h0000;
                        d.phase = PH_RESP_WAIT;
                        d.timer = 24'h000000;
                    end
                    FN_CONFIG: begin
                        if (mdf > MOD_CFG_VU_WORDS) begin
                            set_bits[ST_INVALID] = 1'b1;
                        end else begin
                            d.resp = cfg_word;
                            d.phase = PH_RESP_WAIT;
                            d.timer = 24'h000000;
                        end
                    end
                    FN_CONTROL: begin
                        if (mdf == MOD_RESET_ATTN) begin
                            clr_all = 1'b1;
                        end else if (mdf == MOD_START_MOTOR && q.switches[SW_MOTOR]) begin
                            d.spindle = 1'b1;
                        end else begin
                            set_bits[ST_INVALID] = 1'b1;
                        end
                    end
                    FN_STROBE_OFS: d.strobe_ofs = mdf != 4'h0;
                    FN_TRACK_OFS: begin
                        d.track_ofs = mdf != 4'h0;
                        d.phase = PH_TRACK_WAIT;
                        d.timer = 24'h000000;
                    end
                    FN_DIAG: begin
                        if (error_state) begin
                            d.attention = 1'b1;
                        end
                    end
                    FN_SET_BPS: begin
                        if (param < MIN_BPS) begin
                            set_bits[ST_INVALID] = 1'b1;
                        end else begin
                            d.spt_user = spt_from_param[7:0];
                            d.spt_set = 1'b1;
                        end
                    end
                    default: set_bits[ST_INVALID] = 1'b1;
                endcase
            end
        end

        // An internal fault restores the default characteristics.
        if (reinit_fault) begin
            set_bits[ST_POR] = 1'b1;
            d.spt_set = 1'b0;
            d.track_ofs = 1'b0;
            d.strobe_ofs = 1'b0;
        end
        if (seek_fault) begin
            set_bits[ST_SEEK] = 1'b1;
        end
        if (write_gate && q.track_ofs) begin
            set_bits[ST_WG_OFS] = 1'b1;
        end
        if (vu_status_avail) begin
            set_bits[ST_VU] = 1'b1;
        end
        if (write_fault) begin
            set_bits[ST_WFAULT] = 1'b1;
        end

        // A flag raised in the same cycle as the reset command survives it.
        if (clr_all) begin
            d.flags = 8'h00;
            d.attention = 1'b0;
        end
        d.flags = d.flags | set_bits;
        if (|set_bits) begin
            d.attention = 1'b1;
        end

        d.complete = (d.phase == PH_IDLE) && !exec;
        d.write_en = write_gate && !write_fault && !d.flags[ST_WFAULT]
                     && !d.flags[ST_WG_OFS] && !d.attention && !d.track_ofs;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '{phase: PH_IDLE, timer: 24'h000000, resp: 16'h0000,
                   flags: FLAGS_RESET, attention: 1'b1, complete: 1'b1,
                   spindle: 1'b0, strobe_ofs: 1'b0, track_ofs: 1'b0,
                   write_en: 1'b0, switches: SWITCH_RESET, spt_set: 1'b0,
                   spt_user: 8'h00, pready: 1'b0, pslverr: 1'b0,
                   prdata: 32'h0000_0000};
        end else begin
            q <= d;
        end
    end

    assign pready = q.pready;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr;
    assign attention = q.attention;
    assign cmd_complete = q.complete;
    assign spindle_run = q.spindle;
    assign write_enable = q.write_en;
    assign strobe_offset = q.strobe_ofs;
    assign track_offset = q.track_ofs;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CONTROL_BAD_MOD: assert property (
        exec && !busy && parity_ok && fn == FN_CONTROL
        && mdf != MOD_RESET_ATTN && mdf != MOD_START_MOTOR
        |=> q.flags[ST_INVALID] && q.attention && !q.complete ##1 q.complete)
        else $error("Unlisted control modifier was not refused.");

    AST_RESET_ATTN: assert property (
        exec && !busy && parity_ok && fn == FN_CONTROL && mdf == MOD_RESET_ATTN
        && !seek_fault && !write_fault && !vu_status_avail && !reinit_fault
        && !(write_gate && q.track_ofs)
        |=> !attention && q.flags == 8'h00)
        else $error("Reset command left attention or status set.");

    AST_START_MOTOR: assert property (
        exec && !busy && parity_ok && fn == FN_CONTROL && mdf == MOD_START_MOTOR
        |=> (spindle_run == $past(q.switches[SW_MOTOR]))
        && (q.flags[ST_INVALID] != $past(q.switches[SW_MOTOR])))
        else $error("Start motor did not follow the motor switch.");

    AST_TRACK_TIME: assert property (
        q.phase == PH_TRACK_WAIT |-> q.timer < 24'(TRACK_OFS_CYCLES))
        else $error("Track offset settling ran past its limit.");

    AST_DIAG_QUIET: assert property (
        exec && !busy && parity_ok && fn == FN_DIAG && !error_state && !attention
        && !seek_fault && !write_fault && !vu_status_avail && !reinit_fault
        && !(write_gate && q.track_ofs)
        |=> !attention && !cmd_complete ##1 cmd_complete && !attention)
        else $error("Diagnostics raised attention without an error.");

    AST_BPS_LOW: assert property (
        exec && !busy && parity_ok && fn == FN_SET_BPS && param < MIN_BPS
        |=> q.flags[ST_INVALID] && $stable(q.spt_user))
        else $error("Too small bytes per sector was accepted.");

    AST_WRITE_BLOCK: assert property (
        write_enable |-> !attention && !q.flags[ST_WFAULT] && !$past(write_fault))
        else $error("Writing enabled during fault or attention.");

    AST_CFG_GENERAL: assert property (
        exec && !busy && parity_ok && fn == FN_CONFIG && mdf == MOD_CFG_GENERAL
        |=> q.resp[15:6] == 10'b0011100101 && q.resp[4:3] == 2'b00
        && $onehot(q.resp[2:0]) && q.resp[5] == $past(q.switches[SW_MOTOR]))
        else $error("General configuration word is wrong.");

    AST_CFG_RESERVED: assert property (
        exec && !busy && parity_ok && fn == FN_CONFIG && mdf > MOD_CFG_VU_WORDS
        |=> q.phase == PH_IDLE && q.flags[ST_INVALID] && attention)
        else $error("Reserved configuration request was answered.");

    AST_STAT_READ: assert property (
        apb_setup && !pwrite && paddr == ADDR_STAT
        |=> prdata[15:10] == 6'b010000 && prdata[0] == 1'b0
        && prdata[ST_SPINDLE] == !spindle_run)
        else $error("Standard status fixed bits are wrong.");

    AST_PARITY: assert property (
        exec && !busy && !parity_ok
        |=> q.flags[ST_PARITY] && q.phase == PH_IDLE && $stable(spindle_run))
        else $error("Command with bad parity was executed.");

    AST_BUSY_CMD: assert property (
        exec && busy |=> q.flags[ST_IFACE] && attention)
        else $error("Command during a pending transfer not flagged.");

    AST_ATTN_ON_FAULT: assert property (
        $rose(|q.flags[7:1]) |-> attention)
        else $error("Fault bit set without attention.");

endmodule // disk_serial_command_status_responder
`default_nettype wire

// ---- logic/disk_cmd_pkg.sv ----
`default_nettype none
package disk_cmd_pkg;

    // Register byte addresses on the APB port.
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_RESP = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_SWITCH = 8'h0c;

    // Command word layout: function in 15..12, modifier in 11..8, parity in 16.
    localparam int CMD_FN_LSB = 12;
    localparam int CMD_MOD_LSB = 8;
    localparam int CMD_PARITY_BIT = 16;

    // Command functions.
    localparam logic [3:0] FN_SEEK = 4'h0;
    localparam logic [3:0] FN_RECAL = 4'h1;
    localparam logic [3:0] FN_STATUS = 4'h2;
    localparam logic [3:0] FN_CONFIG = 4'h3;
    localparam logic [3:0] FN_CONTROL = 4'h5;
    localparam logic [3:0] FN_STROBE_OFS = 4'h6;
    localparam logic [3:0] FN_TRACK_OFS = 4'h7;
    localparam logic [3:0] FN_DIAG = 4'h8;
    localparam logic [3:0] FN_SET_BPS = 4'h9;

    // Modifiers.
    localparam logic [3:0] MOD_RESET_ATTN = 4'h0;
    localparam logic [3:0] MOD_START_MOTOR = 4'h3;
    localparam logic [3:0] MOD_CFG_GENERAL = 4'h0;
    localparam logic [3:0] MOD_CFG_CYL_FIXED = 4'h1;
    localparam logic [3:0] MOD_CFG_CYL_REMOV = 4'h2;
    localparam logic [3:0] MOD_CFG_HEADS = 4'h3;
    localparam logic [3:0] MOD_CFG_BPT = 4'h4;
    localparam logic [3:0] MOD_CFG_BPS = 4'h5;
    localparam logic [3:0] MOD_CFG_SPT = 4'h6;
    localparam logic [3:0] MOD_CFG_ISG = 4'h7;
    localparam logic [3:0] MOD_CFG_PLO = 4'h8;
    localparam logic [3:0] MOD_CFG_VU_WORDS = 4'h9;

    // Drive characteristics.
    localparam logic [15:0] BYTES_PER_TRACK = 16'd10440;
    localparam logic [11:0] MIN_BPS = 12'd41;
    localparam logic [15:0] MAX_CYLINDERS = 16'd925;
    localparam logic [15:0] VU_WORDS = 16'd15;
    localparam logic [15:0] ISG_WORD = {8'd12, 8'd16};
    localparam logic [15:0] PLO_WORD = 16'd11;
    localparam logic [15:0] CFG_GENERAL_FIXED = 16'h3940;
    localparam int CFG_MOTOR_BIT = 5;
    localparam logic [15:0] STAT_FIXED = 16'h4000;

    // Standard status bit positions.
    localparam int ST_SPINDLE = 9;
    localparam int ST_POR = 8;
    localparam int ST_PARITY = 7;
    localparam int ST_IFACE = 6;
    localparam int ST_INVALID = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_WG_OFS = 3;
    localparam int ST_VU = 2;
    localparam int ST_WFAULT = 1;

    // Installation switch register fields.
    localparam int SW_MOTOR = 0;
    localparam int SW_SPT_LSB = 1;
    localparam int SW_FMT_LSB = 3;
    localparam int SW_HEADS_LSB = 5;
    localparam logic [7:0] SWITCH_RESET = 8'h00;
    localparam logic [8:1] FLAGS_RESET = 8'h80;

    // Timing.
    localparam int CLK_MHZ = 125;
    localparam int HS_LIMIT_MS = 10;
    localparam int TRACK_OFS_MS = 3;
    localparam int HS_CYCLES = HS_LIMIT_MS * 1000 * CLK_MHZ;
    localparam int TRACK_CYCLES = TRACK_OFS_MS * 1000 * CLK_MHZ;

    typedef enum logic [1:0] {PH_IDLE, PH_TRACK_WAIT, PH_RESP_WAIT} phase_type;

    typedef struct packed {
        phase_type phase;
        logic [23:0] timer;
        logic [15:0] resp;
        logic [8:1] flags;
        logic attention;
        logic complete;
        logic spindle;
        logic strobe_ofs;
        logic track_ofs;
        logic write_en;
        logic [7:0] switches;
        logic spt_set;
        logic [7:0] spt_user;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } state_type;

endpackage
`default_nettype wire

// ---- verif/host_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module host_ctrl_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    import disk_cmd_pkg::*;
    logic err;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // The answer is taken at the rising edge where pready is seen high; only then does the
    // request drop, so the slave never sees a half-released transfer.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // Commands wait for command complete, as a real controller must.
    task automatic cmd(input logic [15:0] w, input logic bad);
        logic [31:0] q;
        q = 32'h0;
        while (q[17] !== 1'b1) xfer(1'b0, ADDR_STAT, 32'h0, q);
        xfer(1'b1, ADDR_CMD, {15'h0, (~^w) ^ bad, w}, q);
    endtask
    // The status word is read before attention is reset.
    task automatic clear_attn();
        logic [31:0] q;
        xfer(1'b0, ADDR_STAT, 32'h0, q);
        cmd({FN_CONTROL, MOD_RESET_ATTN, 8'h00}, 1'b0);
    endtask
    // Callers never pass configuration modifiers 1010 to 1100.
    task automatic ask(input logic [3:0] f, input logic [3:0] m, input int slow,
                       output logic [31:0] q);
        cmd({f, m, 8'h00}, 1'b0);
        repeat (slow) @(posedge pclk);
        xfer(1'b0, ADDR_RESP, 32'h0, q);
    endtask
endmodule // host_ctrl_model
`default_nettype wire

// ---- verif/tb_disk_serial_command_status_responder.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_disk_serial_command_status_responder;
    import disk_cmd_pkg::*;
    localparam int TRK = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic seek_fault, write_fault, write_gate, vu_status_avail, reinit_fault;
    logic attention, cmd_complete, spindle_run, write_enable, strobe_offset, track_offset;
    logic [15:0] swv[3] = '{16'h0001, 16'h002e, 16'h0053};
    logic [15:0] gv[3] = '{16'h0024, 16'h0001, 16'h0022};
    logic [15:0] hv[3] = '{16'd9, 16'd7, 16'd5};
    logic [15:0] sv[3] = '{16'd17, 16'd32, 16'd16};
    logic [15:0] ev[10];
    logic [15:0] p;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n;
    disk_serial_command_status_responder #(.HS_LIMIT_CYCLES(20), .TRACK_OFS_CYCLES(TRK))
        disk_serial_command_status_responder_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .seek_fault(seek_fault), .write_fault(write_fault), .write_gate(write_gate),
        .vu_status_avail(vu_status_avail), .reinit_fault(reinit_fault),
        .attention(attention), .cmd_complete(cmd_complete), .spindle_run(spindle_run),
        .write_enable(write_enable), .strobe_offset(strobe_offset),
        .track_offset(track_offset));
    host_ctrl_model host_ctrl_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
    always #4 pclk = ~pclk;
    task automatic complete_run();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic ck(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        host_ctrl_model_i.xfer(1'b0, a, 32'h0, v);
    endtask
    task automatic cm(input logic [15:0] w);
        host_ctrl_model_i.cmd(w, 1'b0);
    endtask
    task automatic clr();
        host_ctrl_model_i.clear_attn();
    endtask
    // Input changes take one cycle to reach flags and the write enable.
    task automatic st(input string nm, input logic [21:0] e);
        logic [31:0] v;
        v = 32'h0;
        repeat (4) @(posedge pclk);
        while (v[17] !== 1'b1) rd(ADDR_STAT, v);
        ck(nm, v, {10'h0, e});
        ck({nm, "_pins"}, {26'h0, strobe_offset, track_offset, write_enable, spindle_run,
           cmd_complete, attention}, {26'h0, e[21:16]});
    endtask
    task automatic fin(input string nm);
        $display("test %s done", nm);
    endtask
    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {seek_fault, write_fault, write_gate, vu_status_avail, reinit_fault} = 5'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        ck("attn_pin", {31'h0, attention}, 32'h1);
        st("por", 22'h034300);
        rd(8'h10, q);
        ck("unmapped", {31'h0, host_ctrl_model_i.err}, 32'h1);
        clr();
        st("reset_attn", 22'h024200);
        for (int i = 1; i < 16; i++) begin
            cm({FN_CONTROL, 4'(i), 8'h00});
            st("ctl_mod", 22'h034220);
            clr();
        end
        host_ctrl_model_i.xfer(1'b1, ADDR_SWITCH, 32'h01, q);
        cm({FN_CONTROL, MOD_START_MOTOR, 8'h00});
        st("motor", 22'h064000);
        fin("control");
        foreach (swv[k]) begin
            host_ctrl_model_i.xfer(1'b1, ADDR_SWITCH, {16'h0, swv[k]}, q);
            ev = '{CFG_GENERAL_FIXED | gv[k], MAX_CYLINDERS, 16'h0, hv[k], BYTES_PER_TRACK,
                   BYTES_PER_TRACK / sv[k], sv[k], ISG_WORD, PLO_WORD, VU_WORDS};
            for (int m = 0; m < 10; m++) begin
                host_ctrl_model_i.ask(FN_CONFIG, 4'(m), 0, q);
                ck("cfg", q, {15'h0, 1'b1, ev[m]});
            end
        end
        for (int i = 13; i < 16; i++) begin
            host_ctrl_model_i.ask(FN_CONFIG, 4'(i), 0, q);
            ck("no_word", {31'h0, q[16]}, 32'h0);
            st("cfg_rsv", 22'h074020);
            clr();
        end
        fin("config");
        foreach (ev[i]) begin
            p = (i < 2) ? 16'd40 * i : ((i < 4) ? 16'd41 : 16'd4095);
            cm({FN_SET_BPS, p[11:0]});
            if (i < 2) st("bps_bad", 22'h074020);
            if (i < 2) clr();
            host_ctrl_model_i.ask(FN_CONFIG, MOD_CFG_SPT, 0, q);
            ev[9] = (i < 2) ? 16'd16 : BYTES_PER_TRACK / p;
            if (i < 4) ck("spt_set", q, {15'h0, 1'b1, ev[9]});
            host_ctrl_model_i.ask(FN_CONFIG, MOD_CFG_BPS, 0, q);
            if (i < 4) ck("bps_set", q, {15'h0, 1'b1, BYTES_PER_TRACK / ev[9]});
            if (i == 3) break;
        end
        @(posedge pclk) reinit_fault <= 1'b1;
        @(posedge pclk) reinit_fault <= 1'b0;
        st("reinit", 22'h074100);
        host_ctrl_model_i.ask(FN_CONFIG, MOD_CFG_SPT, 0, q);
        ck("spt_dflt", q, {15'h0, 1'b1, 16'd16});
        clr();
        host_ctrl_model_i.cmd({FN_STROBE_OFS, 12'h100}, 1'b1);
        st("parity", 22'h074080);
        clr();
        for (int m = 1; m < 4; m++) begin
            cm({FN_STROBE_OFS, 4'(m), 8'h00});
            st("strobe", 22'h264000);
        end
        cm({FN_STROBE_OFS, 12'h000});
        fin("params");
        cm({FN_TRACK_OFS, 12'h200});
        @(negedge pclk);
        ck("trk_busy", {31'h0, cmd_complete}, 32'h0);
        for (n = 0; n < 40 && cmd_complete !== 1'b1; n++) @(negedge pclk);
        ck("trk_time", {31'h0, n <= TRK}, 32'h1);
        st("trk", 22'h164000);
        @(posedge pclk) write_gate <= 1'b1;
        st("wg_ofs", 22'h174008);
        cm({FN_TRACK_OFS, 12'h000});
        host_ctrl_model_i.xfer(1'b1, ADDR_CMD, 32'h0, q);
        st("busy_cmd", 22'h074048);
        clr();
        st("we", 22'h0e4000);
        @(posedge pclk) write_fault <= 1'b1;
        st("wfault", 22'h074002);
        @(posedge pclk) write_fault <= 1'b0;
        clr();
        @(posedge pclk) vu_status_avail <= 1'b1;
        @(posedge pclk) vu_status_avail <= 1'b0;
        st("vu_attn", 22'h074004);
        @(posedge pclk) write_gate <= 1'b0;
        clr();
        fin("write");
        cm({FN_DIAG, 12'h000});
        st("diag_ok", 22'h064000);
        host_ctrl_model_i.ask(FN_STATUS, 4'h0, 0, q);
        ck("std_word", q, {15'h0, 1'b1, 16'h4000});
        @(posedge pclk) seek_fault <= 1'b1;
        @(posedge pclk) seek_fault <= 1'b0;
        cm({FN_DIAG, 12'h000});
        st("diag_err", 22'h074010);
        clr();
        host_ctrl_model_i.ask(FN_STATUS, 4'h0, 40, q);
        st("hs_late", 22'h074040);
        fin("faults");
        complete_run();
    end
endmodule // tb_disk_serial_command_status_responder
`default_nettype wire
